// >>> design/sbdp_pkg.sv
// package for the subtract datapath: register map, field layout, reset
// values and the flag carrier shared by the top and the subtractor.
// assumes a 32-bit classic wishbone bus with byte addresses.
`default_nettype none
package sbdp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned SBDP_DATA_W = 8;
  localparam int unsigned SBDP_OP_W = 14;
  localparam int unsigned SBDP_FADDR_W = 7;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [9:0] SBDP_OFS_INSTR = 10'h000;
  localparam logic [9:0] SBDP_OFS_ACC = 10'h004;
  localparam logic [9:0] SBDP_OFS_STATUS = 10'h008;
  localparam logic [9:0] SBDP_OFS_RESULT = 10'h00C;
  localparam logic [9:0] SBDP_OFS_LASTOP = 10'h010;
  // file registers occupy 0x200..0x3FC, one word per file address
  localparam logic [9:0] SBDP_OFS_FILE = 10'h200;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int unsigned SBDP_ST_CARRY = 0;
  localparam int unsigned SBDP_ST_NIBBLE = 1;
  localparam int unsigned SBDP_ST_ZERO = 2;
  localparam int unsigned SBDP_ST_BADOP = 3;

  // ----------------------------------------------------------------
  // opcode fields
  // ----------------------------------------------------------------
  localparam logic [1:0] SBDP_LIT_TOP = 2'h3;
  localparam logic [2:0] SBDP_LIT_NIB = 3'h6;
  localparam logic [5:0] SBDP_FILE_TOP = 6'h02;
  localparam int unsigned SBDP_DEST_BIT = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SBDP_ACC_RST = 8'h00;
  localparam logic [7:0] SBDP_RESULT_RST = 8'h00;
  localparam logic [13:0] SBDP_LASTOP_RST = 14'h0000;

  typedef struct packed {
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } sbdp_flags_t;

  localparam sbdp_flags_t SBDP_FLAGS_RST = '{1'b0, 1'b0, 1'b0};

  typedef enum logic [1:0] {
    SBDP_OP_NONE = 2'b00,
    SBDP_OP_LIT = 2'b01,
    SBDP_OP_FILE = 2'b10
  } sbdp_op_t;

endpackage
`default_nettype wire

// >>> design/sbdp_sub.sv
// 8-bit subtractor: minuend minus subtrahend with borrow-style flags.
// purely combinational; the caller registers whatever it keeps.
`default_nettype none
module sbdp_sub
  import sbdp_pkg::*;
#(
  parameter int unsigned W = SBDP_DATA_W
) (
  // operands
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  // result
  output logic [W-1:0] diff,
  output sbdp_flags_t flags
);

  // add the inverted subtrahend plus one; carry out is "no borrow"
  logic [W:0] full_sum;
  logic [4:0] low_sum;

  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff = full_sum[W-1:0];
  // carry is set for a positive or a zero difference
  assign flags.carry = full_sum[W];
  assign flags.nibble_carry_flag = low_sum[4];
  assign flags.zero = (full_sum[W-1:0] == {W{1'b0}});

endmodule
`default_nettype wire

// >>> design/sbdp_top.sv
// subtract datapath: executes the two subtract opcodes written over a
// classic wishbone slave port and keeps accumulator, flags and file regs.
// assumes one synchronous clock and a master that holds each request
// until it sees ack.
`default_nettype none
module sbdp_top
  import sbdp_pkg::*;
#(
  parameter int unsigned FILE_DEPTH = 128
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // datapath state for observation
  output logic [7:0] acc_o,
  output sbdp_flags_t flags_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic sbdp_op_t decode_op(input logic [13:0] op);
    if (op[13:12] == SBDP_LIT_TOP && op[11:9] == SBDP_LIT_NIB) begin
      decode_op = SBDP_OP_LIT;
    end else if (op[13:8] == SBDP_FILE_TOP) begin
      decode_op = SBDP_OP_FILE;
    end else begin
      decode_op = SBDP_OP_NONE;
    end
  endfunction

  function automatic logic reg_hit(input logic [9:0] adr,
                                   input logic [9:0] ofs);
    reg_hit = (adr[9:2] == ofs[9:2]);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  sbdp_flags_t flags_q;
  sbdp_flags_t flags_d;
  logic badop_q;
  logic badop_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [13:0] lastop_q;
  logic [13:0] lastop_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] file_mem [FILE_DEPTH];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i;
  // a write commits on the edge where ack is high, matching the master
  wire wr_commit = req & wb_we_i & ack_q;
  wire hit_instr = reg_hit(wb_adr_i, SBDP_OFS_INSTR);
  wire hit_acc = reg_hit(wb_adr_i, SBDP_OFS_ACC);
  wire hit_status = reg_hit(wb_adr_i, SBDP_OFS_STATUS);
  wire hit_result = reg_hit(wb_adr_i, SBDP_OFS_RESULT);
  wire hit_lastop = reg_hit(wb_adr_i, SBDP_OFS_LASTOP);
  wire hit_file = (wb_adr_i[9] == SBDP_OFS_FILE[9]);
  wire [6:0] bus_fidx = wb_adr_i[8:2];
  // an opcode is 14 bits wide, so both low byte lanes must be present
  wire wr_instr = wr_commit & hit_instr & wb_sel_i[0] & wb_sel_i[1];
  wire wr_acc = wr_commit & hit_acc & wb_sel_i[0];
  wire wr_status = wr_commit & hit_status & wb_sel_i[0];
  wire wr_file = wr_commit & hit_file & wb_sel_i[0];

  // ----------------------------------------------------------------
  // instruction decode and operand select
  // ----------------------------------------------------------------
  wire [13:0] op_word = wb_dat_i[13:0];
  wire sbdp_op_t op_kind = decode_op(op_word);
  wire op_lit = wr_instr & (op_kind == SBDP_OP_LIT);
  wire op_file = wr_instr & (op_kind == SBDP_OP_FILE);
  wire op_bad = wr_instr & (op_kind == SBDP_OP_NONE);
  wire [6:0] op_fidx = op_word[6:0];
  wire op_dest_file = op_word[SBDP_DEST_BIT];
  wire [7:0] file_rd = file_mem[op_fidx];
  // the accumulator is always the subtrahend
  wire [7:0] minuend = op_lit ? op_word[7:0] : file_rd;

  logic [7:0] diff;
  sbdp_flags_t sub_flags;

  sbdp_sub #(
    .W(SBDP_DATA_W)
  ) u_sub (
    .minuend(minuend),
    .subtrahend(acc_q),
    .diff(diff),
    .flags(sub_flags)
  );

  wire exec = op_lit | op_file;
  wire to_acc = op_lit | (op_file & ~op_dest_file);
  wire to_file = op_file & op_dest_file;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    badop_d = badop_q;
    result_d = result_q;
    lastop_d = lastop_q;
    if (wr_acc) begin
      acc_d = wb_dat_i[7:0];
    end
    if (wr_status) begin
      flags_d.carry = wb_dat_i[SBDP_ST_CARRY];
      flags_d.nibble_carry_flag = wb_dat_i[SBDP_ST_NIBBLE];
      flags_d.zero = wb_dat_i[SBDP_ST_ZERO];
      if (wb_dat_i[SBDP_ST_BADOP]) begin
        badop_d = 1'b0;
      end
    end
    if (exec) begin
      flags_d = sub_flags;
      result_d = diff;
      lastop_d = op_word;
    end
    if (to_acc) begin
      acc_d = diff;
    end
    // an unknown opcode sets the sticky flag; set wins over clear
    if (op_bad) begin
      badop_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (hit_file) begin
      rdata_d = {24'h000000, file_mem[bus_fidx]};
    end else if (hit_instr || hit_lastop) begin
      rdata_d = {18'h0, lastop_q};
    end else if (hit_acc) begin
      rdata_d = {24'h000000, acc_q};
    end else if (hit_status) begin
      rdata_d = {28'h0000000, badop_q, flags_q.zero,
                 flags_q.nibble_carry_flag, flags_q.carry};
    end else if (hit_result) begin
      rdata_d = {24'h000000, result_q};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_q <= SBDP_ACC_RST;
      flags_q <= SBDP_FLAGS_RST;
      badop_q <= 1'b0;
      result_q <= SBDP_RESULT_RST;
      lastop_q <= SBDP_LASTOP_RST;
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      badop_q <= badop_d;
      result_q <= result_d;
      lastop_q <= lastop_d;
    end
  end

  // file registers hold no reset value, like plain data ram
  always_ff @(posedge clk_sys) begin
    if (to_file) begin
      file_mem[op_fidx] <= diff;
    end else if (wr_file) begin
      file_mem[bus_fidx] <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign acc_o = acc_q;
  assign flags_o = flags_q;

endmodule
`default_nettype wire

// >>> dv/sbdp_sva.sv
// checker for the subtract datapath top, watching its ports only
// assumes one-wait wishbone and execution at the instruction ack edge
`default_nettype none
module sbdp_sva
  import sbdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] acc_o,
  input wire sbdp_flags_t flags_o
);
  logic opw, go, lit, fil;
  logic [7:0] k;
  assign opw = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i
    & (wb_adr_i[9:2] == 8'h00);
  assign go = opw & (wb_sel_i[1:0] == 2'h3);
  assign lit = go & (wb_dat_i[13:9] == 5'h1E);
  assign fil = go & (wb_dat_i[13:8] == 6'h02);
  assign k = wb_dat_i[7:0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_lit; lit; endsequence
  sequence s_fil0; fil && !wb_dat_i[7]; endsequence
  // unknown opcodes and short byte lanes must leave the datapath alone
  sequence s_skip; opw && !lit && !fil; endsequence
  chk_op_ignored: assert property (s_skip |=>
    $stable(acc_o) && $stable(flags_o)) else $error("ignored opcode acted");
  chk_lit_acc: assert property (s_lit |=>
    acc_o == 8'($past(k) - $past(acc_o))) else $error("bad literal result");
  // file value is unseen: a borrow shows as a wrap of acc plus old acc
  chk_file_carry: assert property (s_fil0 |=>
    flags_o.carry == ({1'b0, acc_o} + {1'b0, $past(acc_o)} < 9'h100))
    else $error("file carry wrong");
  chk_file_dest: assert property (fil && wb_dat_i[7] |=>
    $stable(acc_o)) else $error("acc changed on file dest");
  chk_carry_pos: assert property (s_lit and k > acc_o |=>
    flags_o.carry) else $error("carry not set");
  chk_carry_eq: assert property (s_lit and k == acc_o |=>
    flags_o.carry && flags_o.zero) else $error("equal flags wrong");
  chk_carry_neg: assert property (s_lit and k < acc_o |=>
    !flags_o.carry) else $error("carry not cleared");
  chk_zero_nib: assert property (s_lit |=> (flags_o.zero == (acc_o == 0))
    && flags_o.nibble_carry_flag == ($past(k[3:0]) >= $past(acc_o[3:0])))
    else $error("zero or nibble flag wrong");
endmodule
bind sbdp_top sbdp_sva u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .acc_o(acc_o), .flags_o(flags_o));
`default_nettype wire

// >>> dv/tb_sbdp.sv
// self-checking bench for the subtract datapath over wishbone
// assumes the slave acks each request once, one cycle after taking it
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t: got %h exp %h", $time, g, e); end end
module tb_sbdp
  import sbdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, cyc, stb, we, ack;
  logic [9:0] adr, fa;
  logic [3:0] sel, bsel;
  logic [31:0] dat, rdat, e;
  logic [31:0] exq[$];
  logic [7:0] acc, a, k, d;
  logic [6:0] f;
  sbdp_flags_t flg;
  int errors, cmp_count, cyc_n, seed;

  sbdp_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .acc_o(acc),
    .flags_o(flg));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // request held until ack is sampled, then released for a cycle
  task automatic bus(input logic w, input logic [9:0] ad,
    input logic [31:0] wd);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= wd;
    sel <= bsel;
    @(posedge clk_sys);
    while (ack !== 1'b1) @(posedge clk_sys);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] ad, input logic [31:0] ex);
    exq.push_back(ex);
    bus(1'b0, ad, 32'h0);
  endtask

  function automatic logic [31:0] st(input logic [7:0] m, s);
    return {29'h0, m == s, m[3:0] >= s[3:0], m >= s};
  endfunction

  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
      e = exq.pop_front();
      `CHK(rdat, e)
      if (adr == SBDP_OFS_ACC) `CHK(acc, e[7:0])
      if (adr == SBDP_OFS_STATUS) `CHK(flg, e[2:0])
    end
    cyc_n++;
    if (cyc_n == 3000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    seed = 38;
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    sel = 4'hF;
    bsel = 4'hF;
    dat = 32'h0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(SBDP_OFS_ACC, 32'h0);
    rd(SBDP_OFS_STATUS, 32'h0);
    rd(10'h014, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      a = 8'($random(seed));
      k = (i % 3 == 0) ? a : 8'($random(seed));
      bus(1'b1, SBDP_OFS_ACC, {24'h0, a});
      bus(1'b1, SBDP_OFS_INSTR, {18'h0, 5'h1E, i[0], k});
      rd(SBDP_OFS_ACC, {24'h0, k - a});
      rd(SBDP_OFS_STATUS, st(k, a));
      rd(SBDP_OFS_RESULT, {24'h0, k - a});
      rd(SBDP_OFS_LASTOP, {18'h0, 5'h1E, i[0], k});
    end
    $display("test literal done");
    for (int i = 0; i < 8; i++) begin
      a = 8'($random(seed));
      d = (i == 2) ? a : 8'($random(seed));
      f = 7'($random(seed));
      fa = SBDP_OFS_FILE + {1'b0, f, 2'h0};
      bus(1'b1, fa, {24'h0, d});
      bus(1'b1, SBDP_OFS_ACC, {24'h0, a});
      bus(1'b1, SBDP_OFS_INSTR, {18'h0, 6'h02, i[0], f});
      rd(SBDP_OFS_ACC, {24'h0, i[0] ? a : d - a});
      rd(fa, {24'h0, i[0] ? d - a : d});
      rd(SBDP_OFS_STATUS, st(d, a));
    end
    $display("test file done");
    // unknown opcode and short byte lanes: nothing but the sticky flag moves
    a = 8'($random(seed));
    bus(1'b1, SBDP_OFS_ACC, {24'h0, a});
    bus(1'b1, SBDP_OFS_STATUS, 32'h5);
    bus(1'b1, SBDP_OFS_INSTR, 32'h3000);
    rd(SBDP_OFS_ACC, {24'h0, a});
    rd(SBDP_OFS_STATUS, 32'hD);
    rd(SBDP_OFS_INSTR, {18'h0, 6'h02, 1'b1, f});
    bsel = 4'h1;
    bus(1'b1, SBDP_OFS_INSTR, {18'h0, 5'h1E, 1'b0, a});
    bsel = 4'hF;
    rd(SBDP_OFS_ACC, {24'h0, a});
    bus(1'b1, SBDP_OFS_STATUS, 32'h8);
    rd(SBDP_OFS_STATUS, 32'h0);
    $display("test refused done");
    @(posedge clk_sys);
    end_sim();
  end
endmodule
`default_nettype wire
